// File: tb/sfrc_host.sv
// host side model: drives the serial link and collects the returned bytes
`timescale 1ns/1ps
`default_nettype none
module sfrc_host (
	output var logic       sclk,
	output var logic       cs_n,
	output var logic [3:0] host_io,
	input  wire logic [3:0] io,
	input  wire logic [3:0] io_oe
);
	logic [7:0] got [$];
	logic [3:0] pre_oe;
	logic [3:0] data_oe;

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		host_io = 4'h5;
		pre_oe = 4'h0;
		data_oe = 4'h0;
	end

	// data set after the fall, taken by the device on the rise
	task automatic clk_out(input logic [3:0] d);
		host_io = d;
		#40;
		pre_oe = pre_oe | io_oe;
		sclk = 1'b1;
		#40;
		sclk = 1'b0;
	endtask

	// unused lanes toggle so a stale level never reads as valid
	task automatic shift(input logic [31:0] v, input int n, input int w);
		for (int i = 0; i < n; i += w) begin
			clk_out((w == 4) ? v[31:28] : {~host_io[3:1], v[31]});
			v = v << w;
		end
	endtask

	// no deep power-down state here, so identification may go at any time
	task automatic frame(input logic [7:0] cmd, input logic [31:0] a, input int w, input int na,
			input int nd, input int lanes, input int nb);
		logic [7:0] b;
		got.delete();
		pre_oe = 4'h0;
		// two idle edges let the configuration reach the link domain
		repeat (2) begin
			#40 sclk = 1'b1;
			#40 sclk = 1'b0;
		end
		cs_n = 1'b0;
		shift({cmd, 24'h000000}, 8, w);
		if (na > 0) begin
			shift(a << (32 - na), na, w);
		end
		repeat (nd) clk_out(~host_io);
		for (int k = 0; k < nb; k++) begin
			b = 8'h00;
			for (int j = 0; j < 8; j += lanes) begin
				host_io = ~host_io;
				#39;
				if (k == 0 && j == 0) begin
					data_oe = io_oe;
				end
				b = (lanes == 4) ? {b[3:0], io} : (lanes == 2) ? {b[5:0], io[1:0]} : {b[6:0], io[1]};
				#1 sclk = 1'b1;
				#40 sclk = 1'b0;
			end
			got.push_back(b);
		end
		#40 cs_n = 1'b1;
		host_io = ~host_io;
	endtask
endmodule
`default_nettype wire

// File: tb/sfrc_top_test.sv
// self-checking bench for the serial flash read command engine
`timescale 1ns/1ps
`default_nettype none
module sfrc_top_test
	import sfrc_pkg::*;
;
	localparam logic [127:0] SN = 128'h1F2E_3D4C_5B6A_7988_97A6_B5C4_D3E2_F10F; // arbitrary value
	localparam logic [7:0] ID_MFR = 8'h96; // arbitrary value
	localparam logic [7:0] ID_TYPE = 8'h2B; // arbitrary value
	localparam logic [7:0] ID_CAP = 8'hD4; // arbitrary value

	logic        clock;
	logic        nrst;
	logic        sclk;
	logic        cs_n;
	sfrc_cfg_t   cfg;
	logic [3:0]  host_io;
	logic [3:0]  io_o;
	logic [3:0]  io_oe;
	logic [3:0]  io_wire;
	logic [31:0] mem_addr;
	logic        mem_sfdp_sel;
	logic [7:0]  mem_data;
	logic [7:0]  last_cmd;
	logic        cmd_seen;
	logic        cmd_refused;
	int          n_mismatch;
	int          n_tests;
	int          cyc;
	int          n_seen;
	logic [7:0]  seen_code;
	logic        seen_ref;
	logic [31:0] rnd;
	logic [7:0]  codes [10] = '{8'h03, 8'h13, 8'h0B, 8'h0C, 8'h3B, 8'h3C, 8'h5A, 8'h4B, 8'h9F, 8'h9E};
	int          dsel [4] = '{8, 6, 12, 16};

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic [7:0] pat(input logic sel, input logic [31:0] a);
		return a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24] ^ (sel ? 8'hC3 : 8'h00);
	endfunction

	function automatic logic [7:0] expb(input logic [7:0] c, input logic [31:0] a, input int i,
			input logic wide);
		logic [31:0] base;
		base = wide ? a : {5'h00, cfg.upper_address_bits, a[23:0]};
		case (c)
			8'h9E, 8'h9F: return (i % 3 == 0) ? ID_MFR : (i % 3 == 1) ? ID_TYPE : ID_CAP;
			8'h4B: return SN[127 - 8 * (i % 16) -: 8];
			8'h5A: return pat(1'b1, 32'(a[7:0]) + 32'(i));
			default: return pat(1'b0, base + 32'(i));
		endcase
	endfunction

	assign io_wire = (io_oe & io_o) | (~io_oe & host_io);
	assign mem_data = pat(mem_sfdp_sel, mem_addr);

	sfrc_top #(
		.MFR_ID     (ID_MFR),
		.MEM_TYPE   (ID_TYPE),
		.MEM_CAP    (ID_CAP),
		.SERIAL_NUM (SN)
	) dut (
		.clock (clock), .nrst (nrst), .cfg_in (cfg), .sclk (sclk), .cs_n (cs_n),
		.io_i (io_wire), .io_o (io_o), .io_oe (io_oe), .mem_addr (mem_addr),
		.mem_sfdp_sel (mem_sfdp_sel), .mem_data (mem_data), .last_cmd (last_cmd),
		.cmd_seen (cmd_seen), .cmd_refused (cmd_refused)
	);

	sfrc_host host (.sclk (sclk), .cs_n (cs_n), .host_io (host_io), .io (io_wire), .io_oe (io_oe));

	always #2 clock = ~clock;

	// decode reports and the hang guard; falling edge so the pulse is settled
	always @(negedge clock) begin
		cyc = cyc + 1;
		if (cmd_seen === 1'b1) begin
			n_seen = n_seen + 1;
			seen_code = last_cmd;
			seen_ref = cmd_refused;
		end
		if (cyc == 80000) begin
			n_mismatch = n_mismatch + 1;
			end_of_test();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic run(input logic [7:0] c, input logic [31:0] a, input int nb);
		logic wide, refuse, id, four, dual;
		int na, nd, lanes, n0;
		four = cfg.four_wire_command_mode;
		id = (c == 8'h9E) || (c == 8'h9F);
		dual = (c == 8'h3B) || (c == 8'h3C);
		wide = cfg.addr4_mode || c == 8'h13 || c == 8'h0C || c == 8'h3C;
		refuse = (cfg.busy && (id || c == 8'h03 || c == 8'h13)) || (four && dual);
		na = id ? 0 : (c == 8'h5A || !wide) ? 24 : 32;
		nd = (id || c == 8'h03 || c == 8'h13) ? 0 : four ? dsel[cfg.dummy_sel] : 8;
		lanes = four ? 4 : dual ? 2 : 1;
		n0 = n_seen;
		host.frame(c, (c == 8'h5A) ? {24'h000000, a[7:0]} : a, four ? 4 : 1, na, nd, lanes, nb);
		#1;
		check("oe before data", host.pre_oe, 4'h0);
		check("oe after frame", io_oe, 4'h0);
		check("oe in data", host.data_oe, refuse ? 4'h0 : four ? 4'hF : dual ? 4'h3 : 4'h2);
		check("decodes", 32'(n_seen - n0), 32'h1);
		check("code", seen_code, c);
		check("refused", seen_ref, refuse);
		if (!refuse) begin
			for (int i = 0; i < nb; i++) begin
				check("data byte", host.got[i], expb(c, a, i, wide));
			end
		end
		$display("test done: code %h four %0d addr4 %0d busy %0d", c, four, cfg.addr4_mode, cfg.busy);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		nrst = 1'b0;
		cfg = '0;
		rnd = 32'd61;
		n_mismatch = 0;
		n_tests = 0;
		cyc = 0;
		n_seen = 0;
		repeat (4) @(posedge clock);
		#1 nrst = 1'b1;
		check("addr after reset", mem_addr, 32'h0);
		check("flags after reset", {last_cmd, cmd_seen, cmd_refused, io_oe}, 32'h0);
		$display("test done: reset values");
		// plain, four-wire and busy passes over every code, random fields
		for (int m = 0; m < 3; m++) begin
			for (int c = 0; c < 10; c++) begin
				rnd = lfsr(rnd);
				@(posedge clock);
				#1 cfg = '{busy: m == 2, dummy_sel: rnd[1:0], upper_address_bits: rnd[4:2],
					addr4_mode: rnd[5], four_wire_command_mode: m == 1};
				rnd = lfsr(rnd);
				run(codes[c], rnd, 4);
			end
		end
		@(posedge clock);
		#1 cfg = '{busy: 1'b0, dummy_sel: 2'h0, upper_address_bits: 3'h7, addr4_mode: 1'b0,
			four_wire_command_mode: 1'b0};
		run(8'h4B, 32'h0000_0000, 17);
		run(8'h9E, 32'h0000_0000, 1);
		run(8'h03, 32'h00FF_FFFE, 4);
		@(posedge clock);
		#1 cfg.addr4_mode = 1'b1;
		run(8'h0C, 32'hFFFF_FFFF, 2);
		// four-wire corners: six-clock table dummy, eight-clock fast dummy, busy not refusing
		@(posedge clock);
		#1 cfg = '{busy: 1'b1, dummy_sel: 2'h1, upper_address_bits: 3'h0, addr4_mode: 1'b1,
			four_wire_command_mode: 1'b1};
		run(8'h5A, 32'h0000_01FF, 2);
		run(8'h4B, 32'h0000_0000, 2);
		@(posedge clock);
		#1 cfg.dummy_sel = 2'h0;
		run(8'h0B, 32'h1234_5678, 2);
		end_of_test();
	end
endmodule
`default_nettype wire

// File: verilog/sfrc_pkg.sv
// constants, types and decode helpers for the serial flash read command block
package sfrc_pkg;

	localparam logic [7:0] CMD_SFDP_READ   = 8'h5A;
	localparam logic [7:0] CMD_SERIAL_NUM  = 8'h4B;
	localparam logic [7:0] CMD_IDENT_A     = 8'h9F;
	localparam logic [7:0] CMD_IDENT_B     = 8'h9E;
	localparam logic [7:0] CMD_READ3       = 8'h03;
	localparam logic [7:0] CMD_READ4       = 8'h13;
	localparam logic [7:0] CMD_FAST3       = 8'h0B;
	localparam logic [7:0] CMD_FAST4       = 8'h0C;
	localparam logic [7:0] CMD_DUAL3       = 8'h3B;
	localparam logic [7:0] CMD_DUAL4       = 8'h3C;

	localparam logic [5:0] CMD_CLK_SINGLE  = 6'h08;
	localparam logic [5:0] CMD_CLK_QUAD    = 6'h02;
	localparam logic [5:0] ADDR3_CLK_SINGLE = 6'h18;
	localparam logic [5:0] ADDR4_CLK_SINGLE = 6'h20;
	localparam logic [5:0] ADDR3_CLK_QUAD  = 6'h06;
	localparam logic [5:0] ADDR4_CLK_QUAD  = 6'h08;

	localparam logic [5:0] DUMMY_SINGLE    = 6'h08;
	localparam logic [5:0] DUMMY_SEL0      = 6'h08;
	localparam logic [5:0] DUMMY_SEL1      = 6'h06;
	localparam logic [5:0] DUMMY_SEL2      = 6'h0C;
	localparam logic [5:0] DUMMY_SEL3      = 6'h10;

	localparam logic [2:0] LANES_1         = 3'h1;
	localparam logic [2:0] LANES_2         = 3'h2;
	localparam logic [2:0] LANES_4         = 3'h4;
	localparam logic [3:0] OE_NONE         = 4'h0;
	localparam logic [3:0] OE_SINGLE       = 4'h2;
	localparam logic [3:0] OE_DUAL         = 4'h3;
	localparam logic [3:0] OE_QUAD         = 4'hF;

	localparam logic [31:0] ID_LAST_IDX    = 32'h0000_0002;
	localparam logic [31:0] ADDR_RESET     = 32'h0000_0000;

	typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUMMY, PH_DATA, PH_IGNORE} sfrc_phase_t;

	typedef enum logic [2:0] {K_NONE, K_SFDP, K_UID, K_ID, K_READ, K_FAST, K_DUAL} sfrc_kind_t;

	typedef struct packed {
		logic       busy;
		logic [1:0] dummy_sel;
		logic [2:0] upper_address_bits;
		logic       addr4_mode;
		logic       four_wire_command_mode;
	} sfrc_cfg_t;

	function automatic sfrc_kind_t sfrc_decode(input logic [7:0] code);
		case (code)
			CMD_SFDP_READ: return K_SFDP;
			CMD_SERIAL_NUM: return K_UID;
			CMD_IDENT_A, CMD_IDENT_B: return K_ID;
			CMD_READ3, CMD_READ4: return K_READ;
			CMD_FAST3, CMD_FAST4: return K_FAST;
			CMD_DUAL3, CMD_DUAL4: return K_DUAL;
			default: return K_NONE;
		endcase
	endfunction

	function automatic logic sfrc_is_wide(input logic [7:0] code);
		return (code == CMD_READ4) || (code == CMD_FAST4) || (code == CMD_DUAL4);
	endfunction

	function automatic logic [5:0] sfrc_dummy_clocks(input logic [1:0] sel);
		case (sel)
			2'h0: return DUMMY_SEL0;
			2'h1: return DUMMY_SEL1;
			2'h2: return DUMMY_SEL2;
			default: return DUMMY_SEL3;
		endcase
	endfunction

endpackage

// File: verilog/sfrc_sync.sv
// two flip-flop level synchroniser of parameterised width
`timescale 1ns/1ps
`default_nettype none
module sfrc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q_reg
);

	logic [W-1:0] meta_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q_reg    <= '0;
		end else begin
			meta_reg <= d;
			q_reg    <= meta_reg;
		end
	end

endmodule
`default_nettype wire

// File: verilog/sfrc_top.sv
// serial flash read command engine on the serial link clock
// Function
// RULE1: parameter table read takes 24-bit address; low byte selects start in 256-byte table.
// RULE2: four-wire mode table and serial reads insert 8/6/12/16 dummy clocks per field.
// RULE3: serial number read: ignored address, one dummy byte, then 128-bit number out.
// RULE4: addressing defaults to 24 bits; 4-byte mode makes address phase 32 bits.
// RULE5: identification sends manufacturer, memory type, capacity bytes, MSB first, falling edges.
// RULE6: identification command during erase or program is not decoded; cycle unaffected.
// RULE7: chip select high ends identification output; device waits for next selection.
// RULE8: host avoids identification command while device is in deep power-down.
// RULE9: normal read latches 3-byte address on rising edges, data out on falling.
// RULE10: address advances after every output byte; one read streams whole memory.
// RULE11: normal read during erase, program or write cycle is rejected harmlessly.
// RULE12: 13H read behaves as 03H with a 32-bit address phase.
// RULE13: single-line fast read takes 3-byte address plus exactly 8 dummy clocks.
// RULE14: four-byte fast read variant equals fast read with 32-bit address.
// RULE15: four-wire fast read dummy count 8/6/12/16 comes from dummy field.
// RULE16: no burst wrap-around for fast read in four-wire mode.
// RULE17: dual-output read: single-line address, 8 dummy clocks, two bits per clock out.
// RULE18: 3CH dual read equals 3BH with a 32-bit address phase.
// RULE19: in 3-byte mode upper address byte comes from extended address bits.
// RULE20: outputs stay high impedance while deselected and during command, address, dummy.
`timescale 1ns/1ps
`default_nettype none
module sfrc_top
	import sfrc_pkg::*;
#(
	parameter logic [7:0]   MFR_ID     = 8'hA5, // arbitrary value
	parameter logic [7:0]   MEM_TYPE   = 8'h5C, // arbitrary value
	parameter logic [7:0]   MEM_CAP    = 8'h3E, // arbitrary value
	parameter logic [127:0] SERIAL_NUM = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210 // arbitrary
) (
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire sfrc_cfg_t  cfg_in,
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic [3:0] io_i,
	output logic      [3:0] io_o,
	output logic      [3:0] io_oe,
	output logic      [31:0] mem_addr,
	output logic            mem_sfdp_sel,
	input  wire logic [7:0] mem_data,
	output logic      [7:0] last_cmd,
	output logic            cmd_seen,
	output logic            cmd_refused
);

	// chip select high clears every frame register at once
	wire frm_rst_n = nrst & ~cs_n;

	logic [$bits(sfrc_cfg_t)-1:0] cfg_q;
	sfrc_cfg_t cfg_s;

	// config must be steady for two link clocks before a frame uses it
	sfrc_sync #(.W($bits(sfrc_cfg_t))) u_cfg_sync (
		.clk   (sclk),
		.rst_n (nrst),
		.d     (cfg_in),
		.q_reg (cfg_q)
	);
	assign cfg_s = sfrc_cfg_t'(cfg_q);

	wire four_wire = cfg_s.four_wire_command_mode;

	sfrc_phase_t phase_reg;
	sfrc_phase_t phase_next;
	logic [5:0]  cnt_reg;
	logic [5:0]  cnt_next;
	logic [31:0] sr_reg;
	sfrc_kind_t  kind_reg;
	sfrc_kind_t  dec_kind;
	logic        wide_reg;
	logic [2:0]  lanes_reg;
	logic [2:0]  dbits_reg;
	logic [7:0]  out_sr_reg;
	logic        cmd_tog_reg;
	logic [7:0]  cmd_code_reg;
	logic        refused_reg;

	// shift in on rising edges, one or four lanes
	wire [31:0] sr_shift = four_wire ? {sr_reg[27:0], io_i} : {sr_reg[30:0], io_i[0]}; // RULE9
	wire [7:0]  cmd_code = sr_shift[7:0];
	assign dec_kind = sfrc_decode(cmd_code);

	wire [5:0] cmd_clocks = four_wire ? CMD_CLK_QUAD : CMD_CLK_SINGLE;
	wire       cmd_end    = (phase_reg == PH_CMD) && (cnt_reg == cmd_clocks - 6'h01);

	// parameter table stays 24-bit in every mode
	wire dec_wide_cmd = sfrc_is_wide(cmd_code); // RULE12 RULE14 RULE18
	wire dec_wide     = dec_wide_cmd || (cfg_s.addr4_mode && dec_kind != K_SFDP); // RULE4
	wire dec_busy_refuse = cfg_s.busy && (dec_kind == K_READ || dec_kind == K_ID); // RULE6 RULE11
	// dual output is a single-line command, not offered in four-wire mode
	wire dec_refuse = (dec_kind == K_NONE) || dec_busy_refuse || (four_wire && dec_kind == K_DUAL);
	wire [2:0] dec_lanes = (dec_kind == K_DUAL) ? LANES_2 : (four_wire ? LANES_4 : LANES_1); // RULE17

	wire [5:0] addr_clk_single = wide_reg ? ADDR4_CLK_SINGLE : ADDR3_CLK_SINGLE;
	wire [5:0] addr_clk_quad   = wide_reg ? ADDR4_CLK_QUAD : ADDR3_CLK_QUAD;
	wire [5:0] addr_clocks     = four_wire ? addr_clk_quad : addr_clk_single; // RULE4
	wire       addr_end        = (phase_reg == PH_ADDR) && (cnt_reg == addr_clocks - 6'h01);

	wire       quad_dummy  = four_wire && (kind_reg != K_DUAL);
	wire [5:0] dummy_table = sfrc_dummy_clocks(cfg_s.dummy_sel); // RULE2 RULE15
	wire [5:0] dummy_fixed = quad_dummy ? dummy_table : DUMMY_SINGLE; // RULE13 RULE17
	wire [5:0] dummy_need  = (kind_reg == K_READ) ? 6'h00 : dummy_fixed; // RULE9
	wire       dummy_end   = (phase_reg == PH_DUMMY) && (cnt_reg == dummy_need - 6'h01);

	// 4-byte mode ignores the extended bits entirely
	wire [31:0] addr_short = {5'h00, cfg_s.upper_address_bits, sr_shift[23:0]}; // RULE19
	wire [31:0] addr_in    = wide_reg ? sr_shift : addr_short;
	wire [31:0] addr_sfdp  = {24'h000000, sr_shift[7:0]}; // RULE1
	wire [31:0] addr_uid   = (kind_reg == K_UID) ? ADDR_RESET : addr_in; // RULE3
	wire [31:0] addr_start = (kind_reg == K_SFDP) ? addr_sfdp : addr_uid;

	// plain linear increment in every mode; only the identification index wraps, back to 0 after 2
	wire        byte_done  = (phase_reg == PH_DATA) && (dbits_reg == 3'h0);
	wire        id_wrap    = (kind_reg == K_ID) && (mem_addr == ID_LAST_IDX);
	wire [31:0] addr_inc   = mem_addr + 32'h0000_0001;
	wire [31:0] addr_step  = id_wrap ? ADDR_RESET : addr_inc; // RULE10 RULE16
	wire [31:0] addr_hold  = byte_done ? addr_step : mem_addr;
	wire [31:0] addr_load  = addr_end ? addr_start : addr_hold;
	wire [31:0] addr_next  = cmd_end ? ADDR_RESET : addr_load;

	wire [2:0] dbits_sum  = 3'(dbits_reg + lanes_reg);
	wire [2:0] dbits_next = (phase_reg == PH_DATA) ? dbits_sum : 3'h0;

	always_comb begin
		phase_next = phase_reg;
		cnt_next   = 6'(cnt_reg + 6'h01);
		unique case (phase_reg)
			PH_CMD: begin
				if (cmd_end) begin
					cnt_next = 6'h00;
					if (dec_refuse) begin
						phase_next = PH_IGNORE; // RULE6 RULE11
					end else if (dec_kind == K_ID) begin
						phase_next = PH_DATA; // RULE5
					end else begin
						phase_next = PH_ADDR;
					end
				end
			end
			PH_ADDR: begin
				if (addr_end) begin
					cnt_next   = 6'h00;
					phase_next = (dummy_need == 6'h00) ? PH_DATA : PH_DUMMY; // RULE9
				end
			end
			PH_DUMMY: begin
				if (dummy_end) begin
					cnt_next   = 6'h00;
					phase_next = PH_DATA; // RULE2 RULE13 RULE15
				end
			end
			PH_DATA, PH_IGNORE: begin
				cnt_next = cnt_reg;
			end
		endcase
	end

	always_ff @(posedge sclk or negedge frm_rst_n) begin
		if (!frm_rst_n) begin
			phase_reg    <= PH_CMD;
			cnt_reg      <= 6'h00;
			sr_reg       <= 32'h0000_0000;
			kind_reg     <= K_NONE;
			wide_reg     <= 1'b0;
			lanes_reg    <= LANES_1;
			dbits_reg    <= 3'h0;
			mem_addr     <= ADDR_RESET;
			mem_sfdp_sel <= 1'b0;
		end else begin
			phase_reg    <= phase_next;
			cnt_reg      <= cnt_next;
			sr_reg       <= sr_shift;
			kind_reg     <= cmd_end ? dec_kind : kind_reg;
			wide_reg     <= cmd_end ? dec_wide : wide_reg;
			lanes_reg    <= cmd_end ? dec_lanes : lanes_reg;
			dbits_reg    <= dbits_next;
			mem_addr     <= addr_next;
			mem_sfdp_sel <= cmd_end ? (dec_kind == K_SFDP) : mem_sfdp_sel;
		end
	end

	// mem_data is an asynchronous read; it has half a link clock to settle
	wire [127:0] uid_sh   = SERIAL_NUM << {mem_addr[3:0], 3'h0};
	wire [7:0]   uid_byte = uid_sh[127:120]; // RULE3
	wire [7:0]   id_pick  = (mem_addr[1:0] == 2'h1) ? MEM_TYPE : MEM_CAP;
	wire [7:0]   id_byte  = (mem_addr[1:0] == 2'h0) ? MFR_ID : id_pick; // RULE5
	wire [7:0]   mem_pick = (kind_reg == K_UID) ? uid_byte : mem_data;
	wire [7:0]   src_byte = (kind_reg == K_ID) ? id_byte : mem_pick;
	wire [7:0]   out_sh   = out_sr_reg << lanes_reg;
	wire [7:0]   out_cur  = (dbits_reg == 3'h0) ? src_byte : out_sh;

	wire [3:0] drv_one  = {2'h0, out_cur[7], 1'b0};
	wire [3:0] drv_two  = {2'h0, out_cur[7], out_cur[6]}; // RULE17
	wire [3:0] drv_four = out_cur[7:4];
	wire [3:0] drv_pick = (lanes_reg == LANES_2) ? drv_two : drv_one;
	wire [3:0] drv_bits = (lanes_reg == LANES_4) ? drv_four : drv_pick;
	wire [3:0] oe_pick  = (lanes_reg == LANES_2) ? OE_DUAL : OE_SINGLE;
	wire [3:0] oe_mask  = (lanes_reg == LANES_4) ? OE_QUAD : oe_pick;

	// falling-edge launch; only the data phase ever enables a driver
	always_ff @(negedge sclk or negedge frm_rst_n) begin
		if (!frm_rst_n) begin
			out_sr_reg <= 8'h00;
			io_o       <= 4'h0;
			io_oe      <= OE_NONE; // RULE7 RULE20
		end else if (phase_reg == PH_DATA) begin
			out_sr_reg <= out_cur;
			io_o       <= drv_bits; // RULE5 RULE9
			io_oe      <= oe_mask;
		end
	end

	// decode report to the system clock; code stays steady until the next frame
	always_ff @(posedge sclk or negedge nrst) begin
		if (!nrst) begin
			cmd_tog_reg  <= 1'b0;
			cmd_code_reg <= 8'h00;
			refused_reg  <= 1'b0;
		end else if (cmd_end) begin
			cmd_tog_reg  <= ~cmd_tog_reg;
			cmd_code_reg <= cmd_code;
			refused_reg  <= dec_refuse;
		end
	end

	logic tog_s;
	logic tog_d_reg;

	sfrc_sync #(.W(1)) u_tog_sync (
		.clk   (clock),
		.rst_n (nrst),
		.d     (cmd_tog_reg),
		.q_reg (tog_s)
	);

	wire cmd_evt = tog_s ^ tog_d_reg;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tog_d_reg   <= 1'b0;
			cmd_seen    <= 1'b0;
			last_cmd    <= 8'h00;
			cmd_refused <= 1'b0;
		end else begin
			tog_d_reg   <= tog_s;
			cmd_seen    <= cmd_evt;
			last_cmd    <= cmd_evt ? cmd_code_reg : last_cmd;
			cmd_refused <= cmd_evt ? refused_reg : cmd_refused;
		end
	end

	property p_hiz;
		@(posedge sclk) disable iff (!frm_rst_n)
		(phase_reg != PH_DATA) |-> (io_oe == OE_NONE);
	endproperty
	a_hiz: assert property (p_hiz) else $error("driver on outside data phase"); // RULE20

	property p_cs_release;
		@(posedge clock) disable iff (!nrst)
		cs_n ##1 cs_n |-> (io_oe == OE_NONE);
	endproperty
	a_cs_release: assert property (p_cs_release) else $error("driver on while deselected"); // RULE7

	property p_single_dummy;
		@(posedge sclk) disable iff (!frm_rst_n)
		$rose(phase_reg == PH_DUMMY) && !four_wire
			|-> (phase_reg == PH_DUMMY) [*8] ##1 (phase_reg == PH_DATA);
	endproperty
	a_single_dummy: assert property (p_single_dummy) else $error("single-line dummy not 8"); // RULE13

	property p_quad_dummy6;
		@(posedge sclk) disable iff (!frm_rst_n)
		$rose(phase_reg == PH_DUMMY) && four_wire && (cfg_s.dummy_sel == 2'h1)
			&& (kind_reg == K_UID || kind_reg == K_SFDP)
			|-> (phase_reg == PH_DUMMY) [*6] ##1 (phase_reg == PH_DATA);
	endproperty
	a_quad_dummy6: assert property (p_quad_dummy6) else $error("four-wire dummy not 6"); // RULE2

	property p_quad_fast8;
		@(posedge sclk) disable iff (!frm_rst_n)
		$rose(phase_reg == PH_DUMMY) && four_wire && (cfg_s.dummy_sel == 2'h0) && (kind_reg == K_FAST)
			|-> (phase_reg == PH_DUMMY) [*8] ##1 (phase_reg == PH_DATA);
	endproperty
	a_quad_fast8: assert property (p_quad_fast8) else $error("four-wire fast dummy not 8"); // RULE15

	property p_addr_len;
		@(posedge sclk) disable iff (!frm_rst_n)
		$fell(phase_reg == PH_ADDR) && !four_wire
			|-> ($past(cnt_reg) == ($past(wide_reg) ? 6'h1F : 6'h17));
	endproperty
	a_addr_len: assert property (p_addr_len) else $error("address phase length wrong"); // RULE4

	property p_wide_cmd;
		@(posedge sclk) disable iff (!frm_rst_n)
		cmd_end && (cmd_code == CMD_READ4 || cmd_code == CMD_FAST4 || cmd_code == CMD_DUAL4)
			|=> wide_reg;
	endproperty
	a_wide_cmd: assert property (p_wide_cmd) else $error("cmd not wide"); // RULE12 RULE14 RULE18

	property p_upper;
		@(posedge sclk) disable iff (!frm_rst_n)
		$fell(phase_reg == PH_ADDR) && !$past(wide_reg) && (kind_reg == K_READ || kind_reg == K_FAST)
			|-> (mem_addr[31:24] == {5'h00, cfg_s.upper_address_bits});
	endproperty
	a_upper: assert property (p_upper) else $error("upper byte not extended bits"); // RULE19

	property p_sfdp_addr;
		@(posedge sclk) disable iff (!frm_rst_n)
		$fell(phase_reg == PH_ADDR) && (kind_reg == K_SFDP)
			|-> (mem_addr[31:8] == 24'h000000) && mem_sfdp_sel;
	endproperty
	a_sfdp_addr: assert property (p_sfdp_addr) else $error("table address not 8-bit"); // RULE1

	property p_uid_addr;
		@(posedge sclk) disable iff (!frm_rst_n)
		$fell(phase_reg == PH_ADDR) && (kind_reg == K_UID) |-> (mem_addr == ADDR_RESET) && !mem_sfdp_sel;
	endproperty
	a_uid_addr: assert property (p_uid_addr) else $error("serial number index not cleared"); // RULE3

	property p_id_first;
		@(posedge sclk) disable iff (!frm_rst_n)
		$rose(phase_reg == PH_DATA) && (kind_reg == K_ID) && (lanes_reg == LANES_1)
			|-> (io_o[1] == MFR_ID[7]) && (io_oe == OE_SINGLE);
	endproperty
	a_id_first: assert property (p_id_first) else $error("first id byte not maker"); // RULE5

	property p_busy_refuse;
		@(posedge sclk) disable iff (!frm_rst_n)
		cmd_end && cfg_s.busy && (dec_kind == K_READ || dec_kind == K_ID)
			|=> (phase_reg == PH_IGNORE) ##1 (phase_reg == PH_IGNORE) && (io_oe == OE_NONE);
	endproperty
	a_busy_refuse: assert property (p_busy_refuse) else $error("taken while busy"); // RULE6 RULE11

	property p_normal_no_dummy;
		@(posedge sclk) disable iff (!frm_rst_n)
		$rose(phase_reg == PH_DATA) && (kind_reg == K_READ) |-> ($past(phase_reg) == PH_ADDR);
	endproperty
	a_normal_no_dummy: assert property (p_normal_no_dummy) else $error("read had dummy"); // RULE9

	property p_addr_step;
		@(posedge sclk) disable iff (!frm_rst_n)
		(phase_reg == PH_DATA) && (lanes_reg == LANES_1) && (dbits_reg == 3'h1) && (kind_reg == K_READ)
			|-> ##8 (mem_addr == $past(mem_addr, 8) + 32'h0000_0001);
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("address not advanced"); // RULE10

	property p_dual_out;
		@(posedge sclk) disable iff (!frm_rst_n)
		$rose(phase_reg == PH_DATA) && (kind_reg == K_DUAL)
			|-> (io_oe == OE_DUAL) && ($past(cnt_reg) == 6'h07);
	endproperty
	a_dual_out: assert property (p_dual_out) else $error("dual read lanes or dummy wrong"); // RULE17

endmodule
`default_nettype wire
